// >>> inc/pia_pkg.sv
// Shared constants, types and helpers of the priority interrupt arbiter
package pia_pkg;
  localparam int NUM_LVL  = 8;
  localparam int LVL_W    = 3;
  localparam int PHYS_W   = 4;
  localparam int NUM_PHYS = 16;
  localparam int WORD_W   = 36;
  localparam int ADDR_W   = 4;
  localparam int CAND_W   = 18;

  localparam logic [ADDR_W-1:0] REG_CTRL    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT    = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FWORD   = 4'h8;
  localparam logic [ADDR_W-1:0] REG_DISMISS = 4'hC;

  localparam int CTRL_GLOB_BIT = 0;
  localparam int CTRL_LEN_LSB  = 1;
  localparam int CTRL_PRQ_LSB  = 8;
  localparam int STAT_HELD_LSB = 0;
  localparam int STAT_PEND_BIT = 8;
  localparam int STAT_BUSY_BIT = 9;
  localparam int STAT_LVL_LSB  = 10;
  localparam int STAT_DEV_LSB  = 13;
  localparam int STAT_INT_BIT  = 17;
  localparam int FW_DEV_LSB    = 25;

  localparam logic             GLOB_RST = 1'b0;
  localparam logic [6:0]       LEN_RST  = 7'h00;
  localparam logic [LVL_W-1:0] PRQ_RST  = 3'h0;
  localparam logic [7:0]       HELD_RST = 8'h00;

  localparam int CAND_ICTR  = 0;
  localparam int CAND_IOTH  = 1;
  localparam int CAND_PHYS0 = 2;
  localparam logic [PHYS_W-1:0] PHYS_UNUSED_LO = 4'hC;
  localparam logic [PHYS_W-1:0] PHYS_UNUSED_HI = 4'hE;

  localparam int CLK_PERIOD_NS = 10;
  localparam int FWORD_WAIT_NS = 1000;
  localparam logic [6:0] FWORD_CYC = 7'(FWORD_WAIT_NS / CLK_PERIOD_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_DEMAND, ST_RESP, ST_POLL, ST_FUNC, ST_PEND
  } pia_state_t;

  // Index of lowest set bit, CAND_W when none is set
  function automatic logic [4:0] pia_first(input logic [CAND_W-1:0] v);
    logic [4:0] r;
    r = 5'(CAND_W);
    for (int i = CAND_W - 1; i >= 0; i--) begin
      if (v[i]) r = 5'(i);
    end
    return r;
  endfunction : pia_first

  // Places the physical device number into the function word
  function automatic logic [WORD_W-1:0] pia_put_dev(
      input logic [WORD_W-1:0] w, input logic [PHYS_W-1:0] d);
    logic [WORD_W-1:0] r;
    r = w;
    r[FW_DEV_LSB +: PHYS_W] = d;
    return r;
  endfunction : pia_put_dev
endpackage : pia_pkg

// >>> inc/pia_sel_if.sv
// Selection signals between the arbiter and its two pickers
`timescale 1ns/1ps
interface pia_sel_if;
  logic [7:0]  rec;
  logic [7:0]  held;
  logic        ok;
  logic [2:0]  lvl;
  logic [17:0] cand;
  logic        hit;
  logic        internal;
  logic [3:0]  phys;
  modport lvl_src (output rec, held, input ok, lvl);
  modport lvl_arb (input rec, held, output ok, lvl);
  modport dev_src (output cand, input hit, internal, phys);
  modport dev_arb (input cand, output hit, internal, phys);
endinterface : pia_sel_if

// >>> hdl/pia_lvl_pick.sv
// Highest recognized level and its test against the running program
`timescale 1ns/1ps
module pia_lvl_pick (
  pia_sel_if.lvl_arb sel
);
  import pia_pkg::*;
  logic [4:0] top_rec;
  logic [4:0] cur_lvl;

  always_comb begin
    top_rec = pia_first({10'h000, sel.rec});
    cur_lvl = pia_first({10'h000, sel.held});
    sel.ok  = (top_rec < cur_lvl);
    sel.lvl = top_rec[2:0];
  end
endmodule : pia_lvl_pick

// >>> hdl/pia_dev_pick.sv
// Device selection among responders of the accepted level
`timescale 1ns/1ps
module pia_dev_pick (
  pia_sel_if.dev_arb sel
);
  import pia_pkg::*;
  logic [CAND_W-1:0] vis;
  logic [4:0]        idx;

  always_comb begin
    vis = sel.cand;
    for (int p = 0; p < NUM_PHYS; p++) begin
      if (4'(p) >= PHYS_UNUSED_LO && 4'(p) <= PHYS_UNUSED_HI) begin
        vis[CAND_PHYS0 + p] = 1'b0;
      end
    end
    idx          = pia_first(vis);
    sel.hit      = (idx != 5'(CAND_W));
    sel.internal = (idx <= 5'(CAND_IOTH));
    sel.phys     = sel.internal ? 4'h0 : 4'(idx - 5'(CAND_PHYS0));
  end
endmodule : pia_dev_pick

// >>> hdl/pia_arbiter.sv
// Priority interrupt arbiter: levels, service and function demands
//
// Overview of operation
// - eight levels, zero highest, seven lowest
// - level zero always active, cannot be disabled
// - many requesters share one level
// - recognize levels one-seven only with global and level enable
// - no accept while busy or held higher
// - accept highest level above running program
// - service demand accepts whole level class
// - demand waits bus, beats IO, stalls
// - select counter, internal, channels, front, bridge
// - physical numbers twelve-fourteen never selected
// - internal conditions may raise requests
// - internal selection skips function demand
// - external selection gets function demand answered
// - hold gathered request until microcode starts
// - missing function word becomes zero
// - hardware inserts device number in word
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module pia_arbiter (
  input  wire logic                         clk_in,
  input  wire logic                         arst_n_in,
  input  wire logic [pia_pkg::ADDR_W-1:0]   reg_addr_in,
  input  wire logic [pia_pkg::WORD_W-1:0]   reg_wdata_in,
  input  wire logic                         reg_wr_in,
  input  wire logic                         reg_rd_in,
  output logic      [pia_pkg::WORD_W-1:0]   reg_rdata_out,
  input  wire logic [pia_pkg::NUM_LVL-1:0]  bus_req_in,
  input  wire logic                         bus_busy_in,
  input  wire logic                         io_wait_in,
  input  wire logic [pia_pkg::NUM_PHYS-1:0] svc_resp_in,
  input  wire logic                         ictr_req_in,
  input  wire logic [pia_pkg::LVL_W-1:0]    ictr_lvl_in,
  input  wire logic                         perr_req_in,
  input  wire logic [pia_pkg::LVL_W-1:0]    perr_lvl_in,
  input  wire logic                         fword_vld_in,
  input  wire logic [pia_pkg::WORD_W-1:0]   fword_in,
  input  wire logic                         ucode_start_in,
  output logic                              svc_dem_out,
  output logic      [pia_pkg::LVL_W-1:0]    svc_lvl_out,
  output logic                              io_block_out,
  output logic                              prog_stall_out,
  output logic                              fdem_out,
  output logic      [pia_pkg::PHYS_W-1:0]   fdem_dev_out,
  output logic      [pia_pkg::LVL_W-1:0]    fdem_lvl_out,
  output logic                              intr_pend_out,
  output logic      [pia_pkg::LVL_W-1:0]    intr_lvl_out,
  output logic      [pia_pkg::PHYS_W-1:0]   intr_dev_out,
  output logic                              intr_internal_out,
  output logic      [pia_pkg::WORD_W-1:0]   intr_fword_out
);
  import pia_pkg::*;

  localparam int FW_BOUND = 102;

  pia_sel_if sel ();

  pia_lvl_pick u_lvl (
    .sel (sel.lvl_arb)
  );

  pia_dev_pick u_dev (
    .sel (sel.dev_arb)
  );

  // Register file state
  logic               glob_en_r;
  logic               glob_en_nxt;
  logic [6:0]         len_r;
  logic [6:0]         len_nxt;
  logic [LVL_W-1:0]   prq_r;
  logic [LVL_W-1:0]   prq_nxt;
  logic [WORD_W-1:0]  rdata_r;
  logic [WORD_W-1:0]  rdata_nxt;

  // Arbiter state
  pia_state_t         st_r;
  pia_state_t         st_nxt;
  logic [7:0]         held_r;
  logic [7:0]         held_nxt;
  logic [LVL_W-1:0]   acc_r;
  logic [LVL_W-1:0]   acc_nxt;
  logic [PHYS_W-1:0]  dev_r;
  logic [PHYS_W-1:0]  dev_nxt;
  logic               int_r;
  logic               int_nxt;
  logic [WORD_W-1:0]  fw_r;
  logic [WORD_W-1:0]  fw_nxt;
  logic [6:0]         tmr_r;
  logic [6:0]         tmr_nxt;
  logic               dem_r;
  logic               dem_nxt;
  logic               fdem_r;
  logic               fdem_nxt;
  logic               blk_r;
  logic               blk_nxt;
  logic               stall_r;
  logic               stall_nxt;
  logic               pend_r;
  logic               pend_nxt;

  logic [7:0]         act;
  logic [7:0]         int_lvls;
  logic               dism_w;
  logic [4:0]         dism_idx;

  // Level activity and recognition
  always_comb begin
    act = {len_r & {7{glob_en_r}}, 1'b1};
    int_lvls = ((8'(ictr_req_in) << ictr_lvl_in)
              | (8'(perr_req_in) << perr_lvl_in)
              | (8'(prq_r != 3'h0) << prq_r)) & 8'hFE;
    sel.rec  = (bus_req_in | int_lvls) & act;
    sel.held = held_r;
  end

  // Responders of the accepted level
  always_comb begin
    sel.cand = '0;
    sel.cand[CAND_ICTR] = ictr_req_in && (ictr_lvl_in == acc_r)
                          && (ictr_lvl_in != 3'h0);
    sel.cand[CAND_IOTH] = (perr_req_in && (perr_lvl_in == acc_r)
                           && (perr_lvl_in != 3'h0))
                          || ((prq_r == acc_r) && (prq_r != 3'h0));
    sel.cand[CAND_PHYS0 +: NUM_PHYS] = svc_resp_in;
  end

  assign dism_w   = reg_wr_in && (reg_addr_in == REG_DISMISS);
  assign dism_idx = pia_first({10'h000, held_r});

  // Register file next state
  always_comb begin
    glob_en_nxt = glob_en_r;
    len_nxt     = len_r;
    prq_nxt     = prq_r;
    rdata_nxt   = '0;
    if (reg_wr_in && reg_addr_in == REG_CTRL) begin
      glob_en_nxt = reg_wdata_in[CTRL_GLOB_BIT];
      len_nxt     = reg_wdata_in[CTRL_LEN_LSB +: 7];
      prq_nxt     = reg_wdata_in[CTRL_PRQ_LSB +: LVL_W];
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        REG_CTRL: begin
          rdata_nxt[CTRL_GLOB_BIT]           = glob_en_r;
          rdata_nxt[CTRL_LEN_LSB +: 7]       = len_r;
          rdata_nxt[CTRL_PRQ_LSB +: LVL_W]   = prq_r;
        end
        REG_STAT: begin
          rdata_nxt[STAT_HELD_LSB +: 8]      = held_r;
          rdata_nxt[STAT_PEND_BIT]           = pend_r;
          rdata_nxt[STAT_BUSY_BIT]           = (st_r != ST_IDLE);
          rdata_nxt[STAT_LVL_LSB +: LVL_W]   = acc_r;
          rdata_nxt[STAT_DEV_LSB +: PHYS_W]  = dev_r;
          rdata_nxt[STAT_INT_BIT]            = int_r;
        end
        REG_FWORD: begin
          rdata_nxt = fw_r;
        end
        default: begin
          rdata_nxt = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      glob_en_r <= GLOB_RST;
      len_r     <= LEN_RST;
      prq_r     <= PRQ_RST;
      rdata_r   <= '0;
    end else begin
      glob_en_r <= glob_en_nxt;
      len_r     <= len_nxt;
      prq_r     <= prq_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // Arbiter next state
  always_comb begin
    st_nxt   = st_r;
    held_nxt = held_r;
    acc_nxt  = acc_r;
    dev_nxt  = dev_r;
    int_nxt  = int_r;
    fw_nxt   = fw_r;
    tmr_nxt  = tmr_r;
    dem_nxt  = 1'b0;
    fdem_nxt = 1'b0;
    if (dism_w && dism_idx < 5'd8) begin
      held_nxt[dism_idx[2:0]] = 1'b0;
    end
    case (st_r)
      ST_IDLE: begin
        if (sel.ok) begin
          acc_nxt = sel.lvl;
          st_nxt  = ST_DEMAND;
        end
      end
      ST_DEMAND: begin
        if (!bus_busy_in) begin
          dem_nxt = 1'b1;
          st_nxt  = ST_RESP;
        end
      end
      ST_RESP: begin
        st_nxt = ST_POLL;
      end
      ST_POLL: begin
        if (!sel.hit) begin
          st_nxt = ST_IDLE;
        end else if (sel.internal) begin
          int_nxt = 1'b1;
          dev_nxt = 4'h0;
          fw_nxt  = '0;
          st_nxt  = ST_PEND;
        end else begin
          int_nxt  = 1'b0;
          dev_nxt  = sel.phys;
          fdem_nxt = 1'b1;
          tmr_nxt  = 7'h00;
          st_nxt   = ST_FUNC;
        end
      end
      ST_FUNC: begin
        if (fword_vld_in) begin
          fw_nxt = pia_put_dev(fword_in, dev_r);
          st_nxt = ST_PEND;
        end else if (tmr_r == FWORD_CYC - 7'h01) begin
          fw_nxt = pia_put_dev('0, dev_r);
          st_nxt = ST_PEND;
        end else begin
          tmr_nxt = tmr_r + 7'h01;
        end
      end
      ST_PEND: begin
        if (ucode_start_in) begin
          held_nxt[acc_r] = 1'b1;
          st_nxt          = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    blk_nxt   = (st_nxt == ST_DEMAND);
    stall_nxt = (st_nxt == ST_DEMAND) && io_wait_in;
    pend_nxt  = (st_nxt == ST_PEND);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r    <= ST_IDLE;
      held_r  <= HELD_RST;
      acc_r   <= 3'h0;
      dev_r   <= 4'h0;
      int_r   <= 1'b0;
      fw_r    <= '0;
      tmr_r   <= 7'h00;
      dem_r   <= 1'b0;
      fdem_r  <= 1'b0;
      blk_r   <= 1'b0;
      stall_r <= 1'b0;
      pend_r  <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      held_r  <= held_nxt;
      acc_r   <= acc_nxt;
      dev_r   <= dev_nxt;
      int_r   <= int_nxt;
      fw_r    <= fw_nxt;
      tmr_r   <= tmr_nxt;
      dem_r   <= dem_nxt;
      fdem_r  <= fdem_nxt;
      blk_r   <= blk_nxt;
      stall_r <= stall_nxt;
      pend_r  <= pend_nxt;
    end
  end

  assign reg_rdata_out     = rdata_r;
  assign svc_dem_out       = dem_r;
  assign svc_lvl_out       = acc_r;
  assign io_block_out      = blk_r;
  assign prog_stall_out    = stall_r;
  assign fdem_out          = fdem_r;
  assign fdem_dev_out      = dev_r;
  assign fdem_lvl_out      = acc_r;
  assign intr_pend_out     = pend_r;
  assign intr_lvl_out      = acc_r;
  assign intr_dev_out      = dev_r;
  assign intr_internal_out = int_r;
  assign intr_fword_out    = fw_r;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_lvl_zero_active: assert property (
    (st_r == ST_IDLE && bus_req_in[0] && held_r == 8'h00)
    |=> (st_r == ST_DEMAND && acc_r == 3'h0))
    else $error("level zero request not accepted");

  a_enable_gate: assert property (
    (st_r == ST_IDLE && st_nxt == ST_DEMAND)
    |-> (acc_nxt == 3'h0 || (glob_en_r && len_r[acc_nxt - 3'h1])))
    else $error("inactive level accepted");

  a_one_at_time: assert property (
    (st_r != ST_IDLE) |=> (st_r == ST_IDLE || $stable(acc_r)))
    else $error("accepted level changed mid request");

  a_above_held: assert property (
    (st_r == ST_IDLE && st_nxt == ST_DEMAND && held_r != 8'h00)
    |-> (5'(sel.lvl) < pia_first({10'h000, held_r})))
    else $error("accepted level not above program");

  a_dem_bus_free: assert property (
    $rose(svc_dem_out) |-> ($past(st_r) == ST_DEMAND && !$past(bus_busy_in)))
    else $error("service demand while bus busy");

  a_io_blocked: assert property (
    (st_r == ST_DEMAND && bus_busy_in) |=> (io_block_out && !svc_dem_out))
    else $error("waiting demand not blocking io");

  a_no_unused: assert property (
    fdem_out |-> (fdem_dev_out < PHYS_UNUSED_LO
                  || fdem_dev_out > PHYS_UNUSED_HI))
    else $error("unused physical number selected");

  a_internal_skip: assert property (
    (st_r == ST_POLL && sel.hit && sel.internal)
    |=> (st_r == ST_PEND && !fdem_out && intr_pend_out))
    else $error("internal selection not pending directly");

  a_func_bounded: assert property (
    fdem_out |-> ##[1:FW_BOUND] (st_r == ST_PEND))
    else $error("function word wait not bounded");

  a_zero_word: assert property (
    (st_r == ST_FUNC && !fword_vld_in && tmr_r == FWORD_CYC - 7'h01)
    |=> (fw_r == pia_put_dev('0, dev_r)))
    else $error("missing word not replaced by zero");

  a_dev_field: assert property (
    ($rose(intr_pend_out) && !intr_internal_out)
    |-> (intr_fword_out[FW_DEV_LSB +: PHYS_W] == intr_dev_out))
    else $error("device number missing from word");

  a_pend_hold: assert property (
    (intr_pend_out && !ucode_start_in) |=> (intr_pend_out && $stable(fw_r)))
    else $error("pending request lost before start");
endmodule : pia_arbiter

// >>> tb/pia_dev_model.sv
// Backplane responders: poll answers and function words
`timescale 1ns/1ps
module pia_dev_model (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        svc_dem_in,
  input  wire logic        fdem_in,
  input  wire logic [15:0] mask_in,
  input  wire logic        reply_in,
  input  wire logic [3:0]  dly_in,
  input  wire logic [35:0] word_in,
  output logic      [15:0] svc_resp_out,
  output logic             fword_vld_out,
  output logic      [35:0] fword_out
);
  logic       busy_r;
  logic [3:0] cnt_r;
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      svc_resp_out  <= '0;
      fword_vld_out <= 1'b0;
      fword_out     <= '0;
      busy_r        <= 1'b0;
      cnt_r         <= '0;
    end else begin
      // Whole level answers in the poll cycle, garbage otherwise
      svc_resp_out  <= svc_dem_in ? mask_in : ~svc_resp_out;
      fword_vld_out <= 1'b0;
      fword_out     <= ~fword_out;
      if (fdem_in && reply_in) begin
        busy_r <= 1'b1;
        cnt_r  <= dly_in;
      end else if (busy_r && cnt_r == 4'h0) begin
        busy_r        <= 1'b0;
        fword_vld_out <= 1'b1;
        fword_out     <= word_in;
      end else if (busy_r) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end
endmodule : pia_dev_model

// >>> tb/priority_interrupt_arbiter_tb.sv
// Self-checking bench of the priority interrupt arbiter
`timescale 1ns/1ps
module priority_interrupt_arbiter_tb;
  import pia_pkg::*;
  logic        clk_in = 1'b0, arst_n_in = 1'b0;
  logic [3:0]  reg_addr_in = '0;
  logic [35:0] reg_wdata_in = '0, word = '0;
  logic        reg_wr_in = 1'b0, reg_rd_in = 1'b0, reply = 1'b1;
  logic [7:0]  bus_req_in = '0;
  logic        bus_busy_in = 1'b0, io_wait_in = 1'b0, ucode_start_in = 1'b0;
  logic        ictr_req_in = 1'b0, perr_req_in = 1'b0;
  logic [2:0]  ictr_lvl_in = 3'h2, perr_lvl_in = 3'h2;
  logic [15:0] svc_resp_in, mask = '0;
  logic [3:0]  dly = '0, fdem_dev_out, intr_dev_out;
  logic [35:0] fword_in, reg_rdata_out, intr_fword_out;
  logic        fword_vld_in, svc_dem_out, io_block_out, prog_stall_out;
  logic        fdem_out, intr_pend_out, intr_internal_out;
  logic [2:0]  svc_lvl_out, fdem_lvl_out, intr_lvl_out;
  int          n_errors = 0, samples_checked = 0, seed = 77, a, b, l;
  int          devs[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 15};

  always #5 clk_in = ~clk_in;

  pia_arbiter pia_arbiter_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .bus_req_in(bus_req_in), .bus_busy_in(bus_busy_in),
    .io_wait_in(io_wait_in), .svc_resp_in(svc_resp_in),
    .ictr_req_in(ictr_req_in), .ictr_lvl_in(ictr_lvl_in),
    .perr_req_in(perr_req_in), .perr_lvl_in(perr_lvl_in),
    .fword_vld_in(fword_vld_in), .fword_in(fword_in),
    .ucode_start_in(ucode_start_in), .svc_dem_out(svc_dem_out),
    .svc_lvl_out(svc_lvl_out), .io_block_out(io_block_out),
    .prog_stall_out(prog_stall_out), .fdem_out(fdem_out),
    .fdem_dev_out(fdem_dev_out), .fdem_lvl_out(fdem_lvl_out),
    .intr_pend_out(intr_pend_out), .intr_lvl_out(intr_lvl_out),
    .intr_dev_out(intr_dev_out), .intr_internal_out(intr_internal_out),
    .intr_fword_out(intr_fword_out)
  );

  pia_dev_model pia_dev_model_inst (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .svc_dem_in(svc_dem_out),
    .fdem_in(fdem_out), .mask_in(mask), .reply_in(reply), .dly_in(dly),
    .word_in(word), .svc_resp_out(svc_resp_in),
    .fword_vld_out(fword_vld_in), .fword_out(fword_in)
  );

  task summarize();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  task chk(input string nm, input logic [35:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [35:0] fw(input logic [35:0] w,
                                     input logic [3:0] d);
    logic [35:0] r;
    r = w;
    r[28:25] = d;
    return r;
  endfunction : fw

  function automatic logic sig(input int k);
    return k == 0 ? svc_dem_out : (k == 1 ? fdem_out : intr_pend_out);
  endfunction : sig

  task wt(input int k);
    for (int n = 0; n < 300 && sig(k) !== 1'b1; n++) @(negedge clk_in);
    chk("wait", 36'(sig(k)), 36'h1);
  endtask : wt

  task quiet(input int k, input int c);
    int h;
    h = 0;
    repeat (c) begin
      @(negedge clk_in);
      if (sig(k) !== 1'b0) h++;
    end
    chk("quiet", 36'(h), 36'h0);
  endtask : quiet

  task wr(input logic [3:0] ad, input logic [35:0] d);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] ad, input logic [35:0] m, e);
    @(posedge clk_in);
    reg_addr_in <= ad;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    chk("rdata", reg_rdata_out & m, e);
  endtask : rd

  task arm(input logic [15:0] m, input logic rep);
    @(posedge clk_in);
    mask <= m;
    reply <= rep;
    word <= 36'({$random(seed), $random(seed)});
    dly <= 4'($random(seed));
  endtask : arm

  task serve(input int lv, input logic [3:0] d, input logic intl);
    int f;
    f = 0;
    wt(0);
    chk("svc_lvl", 36'(svc_lvl_out), 36'(lv));
    if (!intl) begin
      wt(1);
      chk("fdem_dev", 36'(fdem_dev_out), 36'(d));
      chk("fdem_lvl", 36'(fdem_lvl_out), 36'(lv));
    end
    for (int n = 0; n < 300 && intr_pend_out !== 1'b1; n++) begin
      @(negedge clk_in);
      if (fdem_out === 1'b1) f++;
    end
    chk("fdem_cnt", 36'(f), 36'h0);
    chk("pend", 36'(intr_pend_out), 36'h1);
    chk("intl", 36'(intr_internal_out), 36'(intl));
    chk("lvl", 36'(intr_lvl_out), 36'(lv));
    if (!intl) chk("dev", 36'(intr_dev_out), 36'(d));
    chk("fword", intr_fword_out,
        intl ? 36'h0 : fw(reply ? word : 36'h0, d));
    repeat (3) @(negedge clk_in);
    chk("pend_hold", 36'(intr_pend_out), 36'h1);
    @(posedge clk_in);
    ucode_start_in <= 1'b1;
    bus_req_in[lv] <= 1'b0;
    ictr_req_in <= 1'b0;
    perr_req_in <= 1'b0;
    @(posedge clk_in);
    ucode_start_in <= 1'b0;
    @(negedge clk_in);
    chk("pend_off", 36'(intr_pend_out), 36'h0);
  endtask : serve

  task dis();
    wr(REG_DISMISS, 36'h0);
  endtask : dis

  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    rd(REG_CTRL, '1, 36'h0);
    rd(REG_STAT, '1, 36'h0);
    wr(REG_STAT, '1);
    rd(REG_STAT, '1, 36'h0);
    rd(4'h2, '1, 36'h0);
    arm(16'h0100, 1'b1);
    bus_req_in[0] <= 1'b1;
    serve(0, 4'h8, 1'b0);
    dis();
    arm(16'hF008, 1'b1);
    bus_req_in[3] <= 1'b1;
    quiet(0, 20);
    wr(REG_CTRL, 36'h1);
    quiet(0, 10);
    wr(REG_CTRL, 36'h9);
    serve(3, 4'h3, 1'b0);
    wr(REG_CTRL, 36'hFF);
    bus_req_in[5] <= 1'b1;
    quiet(0, 20);
    arm(16'h0002, 1'b1);
    bus_req_in[1] <= 1'b1;
    serve(1, 4'h1, 1'b0);
    rd(REG_STAT, 36'hFF, 36'h0A);
    arm(16'h0800, 1'b1);
    dis();
    rd(REG_STAT, 36'hFF, 36'h08);
    dis();
    serve(5, 4'hB, 1'b0);
    dis();
    arm(16'h7000, 1'b1);
    bus_req_in[6] <= 1'b1;
    wt(0);
    quiet(1, 10);
    quiet(2, 10);
    @(posedge clk_in);
    bus_req_in[6] <= 1'b0;
    repeat (10) @(posedge clk_in);
    arm(16'h8000, 1'b0);
    bus_req_in[2] <= 1'b1;
    serve(2, 4'hF, 1'b0);
    rd(REG_FWORD, '1, fw(36'h0, 4'hF));
    dis();
    arm(16'h0001, 1'b1);
    ictr_req_in <= 1'b1;
    perr_req_in <= 1'b1;
    serve(2, 4'h0, 1'b1);
    dis();
    wr(REG_CTRL, 36'h4FF);
    serve(4, 4'h0, 1'b1);
    wr(REG_CTRL, 36'hFF);
    dis();
    arm(16'h0004, 1'b1);
    bus_busy_in <= 1'b1;
    io_wait_in <= 1'b1;
    bus_req_in[7] <= 1'b1;
    quiet(0, 10);
    chk("io_block", 36'(io_block_out), 36'h1);
    chk("stall", 36'(prog_stall_out), 36'h1);
    @(posedge clk_in);
    bus_busy_in <= 1'b0;
    serve(7, 4'h2, 1'b0);
    chk("io_free", 36'(io_block_out), 36'h0);
    @(posedge clk_in);
    io_wait_in <= 1'b0;
    dis();
    for (int i = 0; i < 8; i++) begin
      a = devs[{$random(seed)} % 13];
      b = devs[{$random(seed)} % 13];
      l = 1 + {$random(seed)} % 7;
      arm(16'(1 << a) | 16'(1 << b) | (16'($random(seed)) & 16'h7000), 1);
      bus_req_in[l] <= 1'b1;
      serve(l, 4'(a < b ? a : b), 1'b0);
      dis();
    end
    rd(REG_CTRL, '1, 36'hFF);
    rd(REG_STAT, 36'h2FF, 36'h0);
    summarize();
  end

  initial begin
    #200000;
    n_errors++;
    summarize();
  end
endmodule : priority_interrupt_arbiter_tb
